// ==== hdl/int_prio_pkg.sv ====
// Package: register map, field layout, reset values and sizes of the priority select block
package int_prio_pkg;

    // ********************************************************
    // Sizes
    // ********************************************************
    localparam int NUM_SOURCES = 6;
    localparam int SRC_W       = 3;
    localparam int DATA_W      = 32;
    localparam int ADDR_W      = 4;

    // ********************************************************
    // Register byte offsets
    // ********************************************************
    localparam logic [ADDR_W-1:0] INTERRUPT_PRIORITY_OFFSET = 4'h0;
    localparam logic [ADDR_W-1:0] SERVICE_STATUS_OFFSET     = 4'h4;

    // ********************************************************
    // Priority register fields (one bit per source, upper two fixed)
    // ********************************************************
    localparam int EXT_INT0_LEVEL_SELECT_BIT = 0;
    localparam int TIMER0_LEVEL_SELECT_BIT   = 1;
    localparam int EXT_INT1_LEVEL_SELECT_BIT = 2;
    localparam int TIMER1_LEVEL_SELECT_BIT   = 3;
    localparam int UART0_LEVEL_SELECT_BIT    = 4;
    localparam int TIMER2_LEVEL_SELECT_BIT   = 5;
    localparam int PRIO_FIXED_LSB            = 6;
    localparam logic [1:0] PRIO_FIXED_BITS   = 2'h3;
    localparam logic [7:0] INTERRUPT_PRIORITY_RESET = 8'hc0;
    localparam logic [NUM_SOURCES-1:0] LEVEL_SELECT_RESET = 6'h00;

    // ********************************************************
    // Service status register fields
    // ********************************************************
    localparam int STATUS_LOW_ACTIVE_BIT  = 0;
    localparam int STATUS_HIGH_ACTIVE_BIT = 1;
    localparam int STATUS_LAST_SRC_LSB    = 4;
    localparam int STATUS_LAST_HIGH_BIT   = 7;

    // ********************************************************
    // Reset values of internal state
    // ********************************************************
    localparam logic [SRC_W-1:0]  LAST_SRC_RESET = 3'h0;
    localparam logic [DATA_W-1:0] READDATA_RESET = 32'h0000_0000;
    localparam logic [1:0]        RST_SYNC_RESET = 2'h0;

endpackage

// ==== hdl/pick_bus_if.sv ====
// Interface: carries pending requests and in-service state to the level picker and its grant back
`timescale 1ns/1ps
interface pick_bus_if;
    import int_prio_pkg::*;

    logic [NUM_SOURCES-1:0] pending;
    logic [NUM_SOURCES-1:0] level_sel;
    logic                   low_busy;
    logic                   high_busy;
    logic                   grant;
    logic [SRC_W-1:0]       grant_src;
    logic                   grant_high;

    modport picker (
        input  pending,
        input  level_sel,
        input  low_busy,
        input  high_busy,
        output grant,
        output grant_src,
        output grant_high
    );

    modport owner (
        output pending,
        output level_sel,
        output low_busy,
        output high_busy,
        input  grant,
        input  grant_src,
        input  grant_high
    );
endinterface

// ==== hdl/level_picker.sv ====
// Module: picks the request to take, honouring high and low levels and the in-service state
`timescale 1ns/1ps
module level_picker (
    pick_bus_if.picker bus
);
    import int_prio_pkg::*;

    logic [NUM_SOURCES-1:0] high_req;
    logic [NUM_SOURCES-1:0] low_req;
    logic                   high_ok;
    logic                   low_ok;

    // A high request may break into a low handler, never into a high one;
    // a low request waits while any handler runs
    always_comb begin
        high_req = bus.pending & bus.level_sel;
        low_req  = bus.pending & ~bus.level_sel;
        high_ok  = (|high_req) && !bus.high_busy;
        low_ok   = (|low_req) && !bus.high_busy && !bus.low_busy;
    end

    // ********************************************************
    // Within one level the lowest source number wins
    // ********************************************************
    always_comb begin
        bus.grant      = high_ok || low_ok;
        bus.grant_high = high_ok;
        bus.grant_src  = '0;
        for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
            if (high_ok ? high_req[i] : low_req[i]) begin
                bus.grant_src = SRC_W'(i);
            end
        end
    end
endmodule

// ==== hdl/interrupt_priority_select.sv ====
// Module: interrupt priority select register with Avalon-MM access and level preemption tracking
`timescale 1ns/1ps
module interrupt_priority_select (
    input  wire logic                                  mclk,
    input  wire logic                                  nrst,
    input  wire logic [int_prio_pkg::ADDR_W-1:0]       avs_address,
    input  wire logic                                  avs_read,
    input  wire logic                                  avs_write,
    input  wire logic [int_prio_pkg::DATA_W-1:0]       avs_writedata,
    input  wire logic [3:0]                            avs_byteenable,
    output logic      [int_prio_pkg::DATA_W-1:0]       avs_readdata,
    output logic                                       avs_waitrequest,
    input  wire logic [int_prio_pkg::NUM_SOURCES-1:0]  int_request,
    input  wire logic [int_prio_pkg::NUM_SOURCES-1:0]  int_enable,
    input  wire logic                                  int_global_enable,
    input  wire logic                                  int_return,
    output logic      [int_prio_pkg::NUM_SOURCES-1:0]  level_select,
    output logic                                       take_pulse,
    output logic      [int_prio_pkg::SRC_W-1:0]        take_source,
    output logic                                       take_high,
    output logic                                       low_in_service,
    output logic                                       high_in_service
);
    import int_prio_pkg::*;

    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } bus_state_t;

    // ********************************************************
    // Reset release
    // ********************************************************
    // Reset asserts at once but releases on a clock edge, so no flop
    // sees the release in mid-cycle
    logic [1:0] rst_sync_reg;
    logic [1:0] rst_sync_next;
    logic       rst_n;

    always_comb begin
        rst_sync_next = {rst_sync_reg[0], 1'b1};
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_reg <= RST_SYNC_RESET;
        end else begin
            rst_sync_reg <= rst_sync_next;
        end
    end

    assign rst_n = rst_sync_reg[1];

    // ********************************************************
    // Bus slave
    // ********************************************************
    // Every access answers on the second edge: the first captures the
    // request and read data and drops waitrequest, the second ends the access
    bus_state_t              bus_state_reg;
    bus_state_t              bus_state_next;
    logic                    waitrequest_reg;
    logic                    waitrequest_next;
    logic [DATA_W-1:0]       readdata_reg;
    logic [DATA_W-1:0]       readdata_next;
    logic                    wr_prio;
    logic [NUM_SOURCES-1:0]  level_sel_reg;
    logic [NUM_SOURCES-1:0]  level_sel_next;
    logic                    low_active_reg;
    logic                    high_active_reg;
    logic [SRC_W-1:0]        last_src_reg;
    logic                    last_high_reg;
    logic [DATA_W-1:0]       prio_word;
    logic [DATA_W-1:0]       status_word;

    always_comb begin
        prio_word = '0;
        prio_word[NUM_SOURCES-1:0] = level_sel_reg;
        prio_word[PRIO_FIXED_LSB +: 2] = PRIO_FIXED_BITS;
        status_word = '0;
        status_word[STATUS_LOW_ACTIVE_BIT] = low_active_reg;
        status_word[STATUS_HIGH_ACTIVE_BIT] = high_active_reg;
        status_word[STATUS_LAST_SRC_LSB +: SRC_W] = last_src_reg;
        status_word[STATUS_LAST_HIGH_BIT] = last_high_reg;
    end

    always_comb begin
        bus_state_next   = bus_state_reg;
        readdata_next    = readdata_reg;
        wr_prio          = 1'b0;
        case (bus_state_reg)
            BUS_IDLE: begin
                if (avs_read || avs_write) begin
                    bus_state_next = BUS_ANSWER;
                    if (avs_read) begin
                        case (avs_address)
                            INTERRUPT_PRIORITY_OFFSET: readdata_next = prio_word;
                            SERVICE_STATUS_OFFSET:     readdata_next = status_word;
                            default:                   readdata_next = '0;
                        endcase
                    end
                end
            end
            BUS_ANSWER: begin
                bus_state_next = BUS_IDLE;
                wr_prio = avs_write && avs_byteenable[0]
                          && (avs_address == INTERRUPT_PRIORITY_OFFSET);
            end
            default: begin
                bus_state_next = BUS_IDLE;
            end
        endcase
        waitrequest_next = (bus_state_next != BUS_ANSWER);
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            bus_state_reg   <= BUS_IDLE;
            waitrequest_reg <= 1'b1;
            readdata_reg    <= READDATA_RESET;
        end else begin
            bus_state_reg   <= bus_state_next;
            waitrequest_reg <= waitrequest_next;
            readdata_reg    <= readdata_next;
        end
    end

    // ********************************************************
    // Priority register
    // ********************************************************
    // Only the six select bits are stored; the upper two are constants
    // on read, so a write can never reach them
    always_comb begin
        level_sel_next = level_sel_reg;
        if (wr_prio) begin
            level_sel_next = avs_writedata[NUM_SOURCES-1:0];
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            level_sel_reg <= LEVEL_SELECT_RESET;
        end else begin
            level_sel_reg <= level_sel_next;
        end
    end

    // ********************************************************
    // Level picking and in-service tracking
    // ********************************************************
    pick_bus_if pick ();

    assign pick.pending   = int_request & int_enable & {NUM_SOURCES{int_global_enable}};
    assign pick.level_sel = level_sel_reg;
    assign pick.low_busy  = low_active_reg;
    assign pick.high_busy = high_active_reg;

    level_picker u_picker (
        .bus (pick)
    );

    logic                    low_active_next;
    logic                    high_active_next;
    logic [SRC_W-1:0]        last_src_next;
    logic                    last_high_next;
    logic                    take_pulse_reg;
    logic                    take_pulse_next;

    // A return ends the most recent handler, which is the high one
    // whenever both are open; a grant in the same cycle still opens
    // its level, since the picker saw the state before the return
    always_comb begin
        low_active_next  = low_active_reg;
        high_active_next = high_active_reg;
        last_src_next    = last_src_reg;
        last_high_next   = last_high_reg;
        take_pulse_next  = 1'b0;
        if (int_return) begin
            if (high_active_reg) begin
                high_active_next = 1'b0;
            end else begin
                low_active_next = 1'b0;
            end
        end
        if (pick.grant) begin
            take_pulse_next = 1'b1;
            last_src_next   = pick.grant_src;
            last_high_next  = pick.grant_high;
            if (pick.grant_high) begin
                high_active_next = 1'b1;
            end else begin
                low_active_next = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            low_active_reg  <= 1'b0;
            high_active_reg <= 1'b0;
            last_src_reg    <= LAST_SRC_RESET;
            last_high_reg   <= 1'b0;
            take_pulse_reg  <= 1'b0;
        end else begin
            low_active_reg  <= low_active_next;
            high_active_reg <= high_active_next;
            last_src_reg    <= last_src_next;
            last_high_reg   <= last_high_next;
            take_pulse_reg  <= take_pulse_next;
        end
    end

    // ********************************************************
    // Outputs
    // ********************************************************
    assign avs_readdata    = readdata_reg;
    assign avs_waitrequest = waitrequest_reg;
    assign level_select    = level_sel_reg;
    assign take_pulse      = take_pulse_reg;
    assign take_source     = last_src_reg;
    assign take_high       = last_high_reg;
    assign low_in_service  = low_active_reg;
    assign high_in_service = high_active_reg;
endmodule

// ==== verification/interrupt_priority_select_monitor.sv ====
// Checker: concurrent properties on the priority select block ports
`timescale 1ns/1ps
module interrupt_priority_select_monitor (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic [3:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [5:0]  int_request,
    input wire logic [5:0]  int_enable,
    input wire logic        int_global_enable,
    input wire logic        int_return,
    input wire logic [5:0]  level_select,
    input wire logic        take_pulse,
    input wire logic [2:0]  take_source,
    input wire logic        take_high,
    input wire logic        low_in_service,
    input wire logic        high_in_service
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
    // ********************************************************
    // Register side
    // ********************************************************
    a_upper_ones: assert property (
        avs_read && !avs_waitrequest && avs_address == 4'h0 |-> avs_readdata[7:6] == 2'h3)
        else $error("upper priority bits not read as ones");
    a_read_mirror: assert property (
        avs_read && !avs_waitrequest && avs_address == 4'h0
        |-> avs_readdata[5:0] == level_select)
        else $error("priority read differs from level select");
    a_level_write: assert property (
        avs_write && !avs_waitrequest && avs_address == 4'h0 && avs_byteenable[0]
        |=> level_select == $past(avs_writedata[5:0]))
        else $error("level select did not follow write");
    a_reset_value: assert property (
        $rose(nrst) |-> level_select == 6'h00 && !low_in_service && !high_in_service)
        else $error("state not cleared by reset");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    // ********************************************************
    // Level preemption
    // ********************************************************
    a_low_no_nest: assert property (
        take_pulse && !take_high |-> $past((!low_in_service || int_return) && !high_in_service))
        else $error("low request taken while a handler was open");
    a_high_no_nest: assert property (
        take_pulse && take_high |-> $past(!high_in_service || int_return))
        else $error("high request taken over a high handler");
    a_take_level: assert property (
        take_pulse |-> (take_high ? high_in_service : low_in_service))
        else $error("taken level not marked in service");
    a_pulse_single: assert property (take_pulse |=> !take_pulse)
        else $error("take pulse longer than one cycle");
    c_high_take: cover property (take_pulse && take_high);
    c_low_take: cover property (take_pulse && !take_high);
    c_write_done: cover property (avs_write && !avs_waitrequest);
endmodule
bind interrupt_priority_select interrupt_priority_select_monitor mon_u (
    .mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .int_request(int_request),
    .int_enable(int_enable), .int_global_enable(int_global_enable), .int_return(int_return),
    .level_select(level_select), .take_pulse(take_pulse), .take_source(take_source),
    .take_high(take_high), .low_in_service(low_in_service), .high_in_service(high_in_service)
);

// ==== verification/tb_interrupt_priority_select.sv ====
// Testbench: register access and level preemption checks for the priority select block
`timescale 1ns/1ps
module tb_interrupt_priority_select;
    import int_prio_pkg::*;
    logic        mclk = 0, nrst = 0, avs_read = 0, avs_write = 0, int_return = 0;
    logic        int_global_enable = 0, avs_waitrequest, take_pulse, take_high;
    logic        low_in_service, high_in_service;
    logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic [5:0]  int_request = 6'h00, int_enable = 6'h00, level_select;
    logic [2:0]  take_source;
    int          failures = 0, n_tests = 0, i;
    always #4 mclk = ~mclk;
    interrupt_priority_select dut_u (
        .mclk(mclk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .int_request(int_request),
        .int_enable(int_enable), .int_global_enable(int_global_enable), .int_return(int_return),
        .level_select(level_select), .take_pulse(take_pulse), .take_source(take_source),
        .take_high(take_high), .low_in_service(low_in_service), .high_in_service(high_in_service)
    );
    // ********************************************************
    // Tasks
    // ********************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Request stands until the rising edge that sees waitrequest low; data is taken there
    task automatic bus(input logic        wr,
                       input logic [3:0]  a,
                       input logic [31:0] d,
                       input logic [3:0]  be);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic req(input logic [5:0] v);
        @(posedge mclk);
        int_request <= v;
    endtask
    task automatic ret();
        @(posedge mclk);
        int_return <= 1'b1;
        @(posedge mclk);
        int_return <= 1'b0;
    endtask
    // Watches a fixed window so that a refused request can be seen not to be taken
    task automatic take(input logic exp_p, input logic [2:0] s, input logic h);
        logic seen;
        seen = 1'b0;
        repeat (8) begin
            @(negedge mclk);
            if (take_pulse === 1'b1 && !seen) begin
                seen = 1'b1;
                chk({28'h0, take_high, take_source}, {28'h0, h, s});
            end
        end
        chk({31'h0, seen}, {31'h0, exp_p});
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ********************************************************
    // Sequence
    // ********************************************************
    initial begin
        repeat (3000) @(posedge mclk);
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        int_enable <= 6'h3f;
        int_global_enable <= 1'b1;
        bus(1'b0, INTERRUPT_PRIORITY_OFFSET, 32'h0, 4'hf);
        chk(rd, 32'hc0);
        chk({26'h0, level_select}, 32'h0);
        for (i = 0; i < 6; i++) begin
            bus(1'b1, INTERRUPT_PRIORITY_OFFSET, 32'hffffff00 | (32'h1 << i), 4'hf);
            bus(1'b0, INTERRUPT_PRIORITY_OFFSET, 32'h0, 4'hf);
            chk(rd, 32'hc0 | (32'h1 << i));
            chk({26'h0, level_select}, 32'h1 << i);
        end
        bus(1'b1, INTERRUPT_PRIORITY_OFFSET, 32'h3f, 4'he);
        bus(1'b0, INTERRUPT_PRIORITY_OFFSET, 32'h0, 4'hf);
        chk(rd, 32'he0);
        bus(1'b0, 4'h8, 32'h0, 4'hf);
        chk(rd, 32'h0);
        bus(1'b1, INTERRUPT_PRIORITY_OFFSET, 32'h02, 4'hf);
        req(6'h01);
        take(1'b1, 3'h0, 1'b0);
        req(6'h04);
        take(1'b0, 3'h0, 1'b0);
        req(6'h06);
        take(1'b1, 3'h1, 1'b1);
        chk({30'h0, high_in_service, low_in_service}, 32'h3);
        // Status: both levels open, last take was source 1 at high level
        bus(1'b0, SERVICE_STATUS_OFFSET, 32'h0, 4'hf);
        chk(rd, 32'h93);
        req(6'h04);
        ret();
        take(1'b0, 3'h0, 1'b0);
        chk({30'h0, high_in_service, low_in_service}, 32'h1);
        ret();
        take(1'b1, 3'h2, 1'b0);
        req(6'h00);
        ret();
        int_global_enable <= 1'b0;
        req(6'h01);
        take(1'b0, 3'h0, 1'b0);
        // Reset in mid-run must bring the register back to its reset value
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (2) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        bus(1'b0, INTERRUPT_PRIORITY_OFFSET, 32'h0, 4'hf);
        chk(rd, 32'hc0);
        chk({26'h0, level_select}, 32'h0);
        chk({30'h0, high_in_service, low_in_service}, 32'h0);
        tally_and_finish();
    end
endmodule
